//--- hdl/bmpp_ctrl.sv
// Open-page EDO control and two-word read prefetch for base memory
`timescale 1ns/1ps
module bmpp_ctrl
    import bmpp_pkg::*;
#(
    parameter int AW = 32,
    parameter int DW = 32,
    parameter int RAW = 12
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] base_ctrl,
    input wire logic bank_interleave,
    input wire logic cpu_sys_bus_req,
    input wire logic cpu_sys_bus_we,
    input wire logic cpu_sys_bus_base_hit,
    input wire logic [AW-1:0] cpu_sys_bus_addr,
    input wire logic [DW-1:0] cpu_sys_bus_wdata,
    output logic cpu_sys_bus_ack,
    output logic [DW-1:0] cpu_sys_bus_rdata,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic mem_we_n,
    output logic [RAW-1:0] mem_addr,
    output logic [DW-1:0] mem_wdata,
    input wire logic [DW-1:0] mem_rdata,
    output logic page_open,
    output logic pf_valid
);
    // Both aliases of base memory share one page number, so a hit is found
    // whichever alias the new access comes through
    // Page number of a byte address; bit 28 masked out so both aliases match
    function automatic logic [AW-1:0] page_of(input logic [AW-1:0] a, input logic il);
        logic [AW-1:0] m;
        m = a;
        m[ADDR_HOLD_BIT] = 1'b0;
        if (il) begin
            page_of = m >> (PAGE_BITS_IL + WORD_LSB);
        end else begin
            page_of = m >> (PAGE_BITS_NIL + WORD_LSB);
        end
    endfunction

    // Word index with bit 28 masked, used for sequential compare
    // A read through the other alias still counts as sequential
    function automatic logic [AW-1:0] word_of(input logic [AW-1:0] a);
        logic [AW-1:0] m;
        m = a;
        m[ADDR_HOLD_BIT] = 1'b0;
        word_of = m >> WORD_LSB;
    endfunction

    // Column part of a word address
    // Only the low bits reach the multiplexed memory address pins
    function automatic logic [RAW-1:0] col_of(input logic [AW-1:0] w);
        col_of = w[RAW-1:0];
    endfunction

    // Sequencer, page tracker and prefetch store state
    bmpp_state_e st_q, st_d; // Sequencer state
    logic open_q, open_d; // A page is held open
    logic [AW-1:0] page_q, page_d; // Open page number
    logic keep_q, keep_d; // Keep page open after this access
    logic [AW-1:0] word_q, word_d; // Current word index
    logic we_q, we_d; // Current access is a write
    logic [DW-1:0] wd_q, wd_d; // Write data held
    logic [3:0] cnt_q, cnt_d; // Phase timer
    logic [1:0] pfn_q, pfn_d; // Prefetch words fetched
    logic [DW-1:0] pf0_q, pf0_d; // Prefetch word 0
    logic [DW-1:0] pf1_q, pf1_d; // Prefetch word 1
    logic pfv_q, pfv_d; // Prefetch contents valid
    logic [AW-1:0] pfw_q, pfw_d; // Word index of the prefetch word handed out next
    logic pfsel_q, pfsel_d; // Next prefetch word to hand out
    logic ack_q, ack_d; // Answer to processor
    logic [DW-1:0] rd_q, rd_d; // Read data to processor
    logic ras_q, ras_d; // Row strobe, low active
    logic cas_q, cas_d; // Column strobe, low active
    logic mwe_q, mwe_d; // Memory write enable, low active
    logic [RAW-1:0] ma_q, ma_d; // Multiplexed memory address
    // Decode of the current request
    logic hold_en; // Page holding enabled and EDO assumed
    logic req_hit; // Access falls in the open page
    logic req_seq; // Read continues from the last one

    // Page holding only valid with EDO; SDRAM setups must keep bit 7 clear
    assign hold_en = base_ctrl[CTRL_HOLD_BIT];
    // Open-page compare only counts while a page is really held
    assign req_hit = open_q && (page_of(cpu_sys_bus_addr, bank_interleave) == page_q);
    // Sequential compare needs words in the store; base writes empty it first
    assign req_seq = pfv_q && (word_of(cpu_sys_bus_addr) == pfw_q);

    // Next-state logic for sequencer, page tracker and prefetch FIFO
    always_comb begin
        st_d = st_q;
        open_d = open_q;
        page_d = page_q;
        keep_d = keep_q;
        word_d = word_q;
        we_d = we_q;
        wd_d = wd_q;
        cnt_d = cnt_q;
        pfn_d = pfn_q;
        pf0_d = pf0_q;
        pf1_d = pf1_q;
        pfv_d = pfv_q;
        pfw_d = pfw_q;
        pfsel_d = pfsel_q;
        ack_d = 1'b0;
        rd_d = rd_q;
        ras_d = ras_q;
        cas_d = 1'b1;
        mwe_d = 1'b1;
        ma_d = ma_q;
        case (st_q)
            BMPP_IDLE: begin
                // Non-base requests leave the prefetch contents alone
                // The request answered last edge is still up; do not take it twice
                if (cpu_sys_bus_req && cpu_sys_bus_base_hit && !ack_q) begin
                    word_d = word_of(cpu_sys_bus_addr);
                    we_d = cpu_sys_bus_we;
                    wd_d = cpu_sys_bus_wdata;
                    // A store hit leaves the page record alone: the row on the pins
                    // still belongs to the last memory access
                    keep_d = hold_en && cpu_sys_bus_addr[ADDR_HOLD_BIT];
                    if (cpu_sys_bus_we) begin
                        pfv_d = 1'b0;
                    end
                    if (!cpu_sys_bus_we && req_seq && hold_en) begin
                        // Sequential hit: answer from FIFO, no memory wait
                        rd_d = pfsel_q ? pf1_q : pf0_q;
                        ack_d = 1'b1;
                        pfw_d = pfw_q + 1'b1;
                        pfsel_d = ~pfsel_q;
                        if (pfsel_q) begin
                            pfv_d = 1'b0;
                        end
                        if (!cpu_sys_bus_addr[ADDR_HOLD_BIT]) begin
                            // No holding through this alias: drop the row now
                            open_d = 1'b0;
                            ras_d = 1'b1;
                        end
                        st_d = BMPP_IDLE;
                    end else if (req_hit) begin
                        // Same page: row stays low, column cycle only
                        ma_d = col_of(word_of(cpu_sys_bus_addr));
                        cnt_d = T_COL + T_SEQ_SAVE;
                        st_d = BMPP_COL;
                    end else begin
                        // Miss: precharge row first
                        // New page recorded here at the miss, before the row is opened
                        page_d = page_of(cpu_sys_bus_addr, bank_interleave);
                        ras_d = 1'b1;
                        cnt_d = T_PRECHARGE;
                        st_d = BMPP_PRE;
                    end
                end
            end
            BMPP_PRE: begin
                // Row strobe high for the precharge time, then row address and strobe
                if (cnt_q == 4'h0) begin
                    // The page counts as open from the row strobe onwards
                    ras_d = 1'b0;
                    ma_d = col_of(page_q);
                    open_d = 1'b1;
                    cnt_d = T_ROW;
                    st_d = BMPP_ROW;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            BMPP_ROW: begin
                // Row to column delay, then the column address goes out
                if (cnt_q == 4'h0) begin
                    ma_d = col_of(word_q);
                    cnt_d = T_COL + T_SEQ_SAVE;
                    st_d = BMPP_COL;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            BMPP_COL: begin
                // Column strobe pulses while row strobe stays asserted
                cas_d = 1'b0;
                mwe_d = ~we_q;
                if (cnt_q == 4'h0) begin
                    // Data has been on the pins since the strobe fell
                    rd_d = mem_rdata;
                    ack_d = 1'b1;
                    cas_d = 1'b1;
                    pfn_d = 2'h0;
                    pfv_d = 1'b0;
                    // Writes, and reads with page holding disabled, skip the prefetch
                    if (!we_q && hold_en) begin
                        ma_d = col_of(word_q + 1'b1);
                        pfw_d = word_q + 1'b1;
                        st_d = BMPP_PFW;
                    end else begin
                        st_d = BMPP_DONE;
                    end
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            BMPP_PFW: begin
                // Two words ahead of the read go into the FIFO
                // Limitation: the row is not changed here, so words past the end
                // of the open page would come from the wrong row
                if (cas_q) begin
                    // Strobe low for one clock per word
                    cas_d = 1'b0;
                end else begin
                    if (pfn_q == 2'h0) begin
                        pf0_d = mem_rdata;
                    end else begin
                        pf1_d = mem_rdata;
                    end
                    pfn_d = pfn_q + 2'h1;
                    // Second word's column; harmless after the last word
                    ma_d = col_of(word_q + 2'h2);
                    if (pfn_q == 2'(PF_WORDS - 1)) begin
                        pfv_d = 1'b1;
                        pfsel_d = 1'b0;
                        st_d = BMPP_DONE;
                    end
                end
            end
            BMPP_DONE: begin
                // Keep or close the page depending on address bit 28
                if (keep_q) begin
                    // Row strobe stays low to hold the page
                    open_d = 1'b1;
                end else begin
                    // Row strobe rises to close the page
                    open_d = 1'b0;
                    ras_d = 1'b1;
                end
                st_d = BMPP_IDLE;
            end
            default: begin
                // Unused codes fall back to idle
                st_d = BMPP_IDLE;
            end
        endcase
    end

    // State registers; reset closes the page and empties the FIFO
    // Data registers are reset too so that no unknown reaches the pins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= BMPP_IDLE;
            open_q <= 1'b0;
            page_q <= '0;
            keep_q <= 1'b0;
            word_q <= '0;
            we_q <= 1'b0;
            wd_q <= '0;
            cnt_q <= 4'h0;
            pfn_q <= 2'h0;
            pf0_q <= '0;
            pf1_q <= '0;
            pfv_q <= 1'b0;
            pfw_q <= '0;
            pfsel_q <= 1'b0;
            ack_q <= 1'b0;
            rd_q <= '0;
            ras_q <= 1'b1;
            cas_q <= 1'b1;
            mwe_q <= 1'b1;
            ma_q <= '0;
        end else begin
            st_q <= st_d;
            open_q <= open_d;
            page_q <= page_d;
            keep_q <= keep_d;
            word_q <= word_d;
            we_q <= we_d;
            wd_q <= wd_d;
            cnt_q <= cnt_d;
            pfn_q <= pfn_d;
            pf0_q <= pf0_d;
            pf1_q <= pf1_d;
            pfv_q <= pfv_d;
            pfw_q <= pfw_d;
            pfsel_q <= pfsel_d;
            ack_q <= ack_d;
            rd_q <= rd_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            mwe_q <= mwe_d;
            ma_q <= ma_d;
        end
    end

    // Outputs straight from flip-flops
    // Processor side
    assign cpu_sys_bus_ack = ack_q;
    assign cpu_sys_bus_rdata = rd_q;
    // Memory side
    assign row_strobe_n = ras_q;
    assign column_strobe_n = cas_q;
    assign mem_we_n = mwe_q;
    assign mem_addr = ma_q;
    assign mem_wdata = wd_q;
    // Status
    assign page_open = open_q;
    assign pf_valid = pfv_q;
endmodule

//--- inc/bmpp_pkg.sv
// Constants and types for the base memory page and prefetch block
package bmpp_pkg;
    // Address bit that requests page holding
    localparam int ADDR_HOLD_BIT = 28;
    // Control bit position of the page-hold enable
    localparam int CTRL_HOLD_BIT = 7;
    // Word address low bit (byte address of a 4-byte word)
    localparam int WORD_LSB = 2;
    // Page word-offset width: 512 words interleaved, 256 otherwise
    localparam int PAGE_BITS_IL = 9;
    localparam int PAGE_BITS_NIL = 8;
    // Words fetched ahead after a read
    localparam int PF_WORDS = 2;
    // Strobe phase lengths in clocks
    localparam logic [3:0] T_PRECHARGE = 4'h2;
    localparam logic [3:0] T_ROW = 4'h2;
    localparam logic [3:0] T_COL = 4'h1;
    // Extra latency saved on a sequential hit
    localparam logic [3:0] T_SEQ_SAVE = 4'h3;
    // Sequencer states
    typedef enum logic [2:0] {
        BMPP_IDLE = 3'b000,
        BMPP_PRE = 3'b001,
        BMPP_ROW = 3'b010,
        BMPP_COL = 3'b011,
        BMPP_PFW = 3'b100,
        BMPP_DONE = 3'b101
    } bmpp_state_e;
endpackage

//--- verification/bmpp_ctrl_asserts.sv
// Port checks for the page and prefetch controller
`timescale 1ns/1ps
module bmpp_ctrl_asserts
    import bmpp_pkg::*;
#(parameter int AW = 32, parameter int DW = 32, parameter int RAW = 12) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] base_ctrl,
    input wire logic bank_interleave,
    input wire logic cpu_sys_bus_req,
    input wire logic cpu_sys_bus_we,
    input wire logic cpu_sys_bus_base_hit,
    input wire logic [AW-1:0] cpu_sys_bus_addr,
    input wire logic [DW-1:0] cpu_sys_bus_wdata,
    input wire logic cpu_sys_bus_ack,
    input wire logic [DW-1:0] cpu_sys_bus_rdata,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic mem_we_n,
    input wire logic [RAW-1:0] mem_addr,
    input wire logic [DW-1:0] mem_wdata,
    input wire logic [DW-1:0] mem_rdata,
    input wire logic page_open,
    input wire logic pf_valid
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_reset_idle:
        assert property (disable iff (1'b0) !rstn |=> !cpu_sys_bus_ack && row_strobe_n
            && column_strobe_n && !page_open && !pf_valid) else $error("reset state wrong");
    a_ack_cause:
        assert property (cpu_sys_bus_ack |-> $past(cpu_sys_bus_req && cpu_sys_bus_base_hit))
        else $error("ack without base request");
    a_write_clears:
        assert property (cpu_sys_bus_ack && cpu_sys_bus_we |=> !pf_valid)
        else $error("write kept prefetch");
    a_cas_under_ras:
        assert property ($fell(column_strobe_n) |-> !row_strobe_n) else $error("cas without ras");
    a_precharge_len:
        assert property ($fell(row_strobe_n) |-> $past(row_strobe_n, 2))
        else $error("precharge too short");
    a_close_page:
        assert property (cpu_sys_bus_ack && !cpu_sys_bus_addr[28] |-> ##[0:12] !page_open)
        else $error("page not closed");
    a_hold_open:
        assert property (cpu_sys_bus_ack && cpu_sys_bus_addr[28] && base_ctrl[7]
            && !$past(pf_valid) |-> ##[0:8] page_open) else $error("page not held");
    a_pf_needs_hold:
        assert property ($rose(pf_valid) |-> base_ctrl[7]) else $error("prefetch without hold");
    a_rdata_on_ack:
        assert property ($changed(cpu_sys_bus_rdata) |-> cpu_sys_bus_ack)
        else $error("read data moved without ack");
    a_we_in_page:
        assert property (!mem_we_n |-> !row_strobe_n) else $error("write strobe without row");
    // Main scenarios reached
    c_fifo_hit: cover property (cpu_sys_bus_ack && $past(pf_valid));
    c_page_held: cover property ($rose(page_open));
    c_fifo_drain: cover property ($fell(pf_valid));
endmodule
bind bmpp_ctrl bmpp_ctrl_asserts #(.AW(AW), .DW(DW), .RAW(RAW)) u_chk (.*);

//--- verification/bmpp_ctrl_test.sv
// Self-checking bench for the page and prefetch controller
`timescale 1ns/1ps
module bmpp_ctrl_test;
    import bmpp_pkg::*;
    logic core_clk, rstn, bank_interleave, cpu_sys_bus_req, cpu_sys_bus_we, cpu_sys_bus_base_hit;
    logic cpu_sys_bus_ack, row_strobe_n, column_strobe_n, mem_we_n, page_open, pf_valid;
    logic [7:0] base_ctrl;
    logic [31:0] cpu_sys_bus_addr, cpu_sys_bus_wdata, cpu_sys_bus_rdata, mem_wdata, mem_rdata;
    logic [11:0] mem_addr;
    // Model words at base, plus 4 and plus 8: row, column, fixed low byte
    localparam logic [31:0] d0 = 32'h0000_005a;
    localparam logic [31:0] d1 = 32'h0000_015a;
    localparam logic [31:0] d2 = 32'h0000_025a;
    int miscompares, total_checks, lat, l0;
    localparam logic [31:0] BA = 32'h1000_0000; // Base memory with the hold bit set
    bmpp_ctrl dut (.*);
    bmpp_edo_model u_mem (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus cycle held until ack; lat counts clocks, 40 means no answer
    task automatic acc(input logic w, input logic [31:0] a, input logic hit, input int gap);
        @(posedge core_clk);
        cpu_sys_bus_req <= 1'b1;
        cpu_sys_bus_we <= w;
        cpu_sys_bus_addr <= a;
        cpu_sys_bus_wdata <= ~a;
        cpu_sys_bus_base_hit <= hit;
        lat = 0;
        do begin
            @(negedge core_clk);
            lat++;
        end while (cpu_sys_bus_ack !== 1'b1 && lat < 40);
        @(posedge core_clk);
        cpu_sys_bus_req <= 1'b0;
        // Leave room for close and prefetch cycles
        repeat (gap) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    // Two sequential reads come from the prefetch store, fast
    task automatic t_prefetch;
        @(posedge core_clk);
        base_ctrl <= 8'h80;
        acc(1'b0, BA, 1'b1, 14);
        l0 = lat;
        chk(cpu_sys_bus_rdata, d0);
        chk({page_open, pf_valid}, 2'b11);
        acc(1'b0, BA + 4, 1'b1, 0);
        chk(lat + T_SEQ_SAVE <= l0, 1'b1);
        chk(cpu_sys_bus_rdata, d1);
        acc(1'b0, BA + 8, 1'b1, 0);
        chk(lat + T_SEQ_SAVE <= l0, 1'b1);
        chk(cpu_sys_bus_rdata, d2);
        chk(pf_valid, 1'b0);
        repeat (14) @(posedge core_clk);
    endtask
    // Prefetched words survive a foreign access, then a base write drops them
    task automatic t_foreign_write;
        acc(1'b0, BA, 1'b1, 14);
        acc(1'b0, 32'h2000_0000, 1'b0, 2);
        chk(lat, 40);
        acc(1'b0, BA + 4, 1'b1, 0);
        chk(lat + T_SEQ_SAVE <= l0, 1'b1);
        chk(cpu_sys_bus_rdata, d1);
        acc(1'b1, BA + 32'h40, 1'b1, 14);
        chk(pf_valid, 1'b0);
        chk(mem_wdata, ~(BA + 32'h40));
        acc(1'b0, BA + 8, 1'b1, 14);
        chk(lat > T_SEQ_SAVE, 1'b1);
        chk(cpu_sys_bus_rdata, d2);
    endtask
    // Alias without the hold bit reads the same word and closes the page
    task automatic t_alias_close;
        acc(1'b0, BA - 32'h1000_0000 + 8, 1'b1, 14);
        chk(cpu_sys_bus_rdata, d2);
        chk(page_open, 1'b0);
    endtask
    // 0x100 and 0x500 share a 2 KB page but not a 1 KB page
    task automatic t_page_size;
        int lm;
        for (int il = 0; il < 2; il++) begin
            @(posedge core_clk);
            bank_interleave <= il[0];
            acc(1'b0, BA + 32'h100, 1'b1, 14);
            acc(1'b0, BA + 32'h500, 1'b1, 14);
            if (il == 0) lm = lat;
        end
        chk(lat < lm, 1'b1);
    endtask
    // Without the enable bit nothing is held or fetched ahead
    task automatic t_no_hold;
        @(posedge core_clk);
        base_ctrl <= 8'h00;
        acc(1'b0, BA + 32'h200, 1'b1, 14);
        chk({page_open, pf_valid}, 2'b00);
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred clocks the tests need
    initial begin
        #2000000;
        miscompares++;
        stop_test;
    end
    initial begin
        rstn = 1'b0;
        base_ctrl = 8'h00;
        bank_interleave = 1'b0;
        cpu_sys_bus_req = 1'b0;
        cpu_sys_bus_we = 1'b0;
        cpu_sys_bus_base_hit = 1'b0;
        cpu_sys_bus_addr = 32'h0;
        cpu_sys_bus_wdata = 32'h0;
        miscompares = 0;
        total_checks = 0;
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        @(negedge core_clk);
        chk({row_strobe_n, column_strobe_n, page_open, pf_valid}, 4'b1100);
        t_prefetch;
        t_foreign_write;
        t_alias_close;
        t_page_size;
        t_no_hold;
        stop_test;
    end
endmodule

//--- verification/bmpp_edo_model.sv
// EDO DRAM model for the base memory side
`timescale 1ns/1ps
module bmpp_edo_model (
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic [11:0] mem_addr,
    output logic [31:0] mem_rdata
);
    logic [11:0] row_q; // Row latched on the row strobe
    logic [31:0] out_q; // Data on the data lines
    // Row capture; the delay lets the registered address settle first
    always @(negedge row_strobe_n) #1 row_q = mem_addr;
    // Word depends on row and column, so two addresses that share a word give one value
    always @(negedge column_strobe_n) #1 out_q = {row_q, mem_addr, 8'h5a};
    // Once the column strobe rises the old word must not linger
    always @(posedge column_strobe_n) out_q = ~out_q;
    assign mem_rdata = out_q;
endmodule
